// ==== dv/adcg_properties.sv ====
// port checker for the converter control block
// assumes binding to adcg_top, one clock domain
`timescale 1ns/100ps
`default_nettype none

module adcg_chk
(
  input wire logic CORE_CLK,
  input wire logic RST_B,
  input wire logic [3:0] AVM_ADDRESS,
  input wire logic AVM_READ,
  input wire logic AVM_WRITE,
  input wire logic [31:0] AVM_READDATA,
  input wire logic AVM_WAITREQUEST,
  input wire logic [10:0] DAC_CODE,
  input wire logic [4:0] CH_SEL,
  input wire logic CONV_ACTIVE,
  input wire logic [15:0] PORT_OE,
  input wire logic [15:0] PIN_IN,
  input wire logic [15:0] PAD_OE,
  input wire logic [15:0] PAD_PULL,
  input wire logic [15:0] PAD_IBE,
  input wire logic [15:0] PORT_RDATA,
  input wire logic IRQ
);
  // ****
  // properties
  // ****
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);
  sequence s_req;
    (AVM_READ || AVM_WRITE) && AVM_WAITREQUEST;
  endsequence
  sequence s_ans;
    !AVM_WAITREQUEST ##1 AVM_WAITREQUEST;
  endsequence
  sequence s_ack_rd;
    AVM_READ && !AVM_WAITREQUEST;
  endsequence
  property p_bus;
    s_req |=> s_ans;
  endproperty
  property p_unmapped;
    s_ack_rd and AVM_ADDRESS > 4'ha |-> AVM_READDATA == 32'h0;
  endproperty
  property p_res_hi;
    s_ack_rd and AVM_ADDRESS == 4'h4 |-> AVM_READDATA[31:2] == 30'h0;
  endproperty
  property p_pad_oe;
    (PAD_OE & ~$past(PORT_OE)) == 16'h0;
  endproperty
  property p_rdata;
    (PORT_RDATA & ~$past(PIN_IN)) == 16'h0;
  endproperty
  property p_ibe;
    ((PAD_OE | PAD_PULL | PORT_RDATA) & ~PAD_IBE) == 16'h0;
  endproperty
  property p_dis;
    (CH_SEL == 5'h1f) [*2] |-> !CONV_ACTIVE;
  endproperty
  property p_len;
    $rose(CONV_ACTIVE) |-> CONV_ACTIVE [*8];
  endproperty
  property p_msb;
    $rose(CONV_ACTIVE) |-> ##[0:2] (DAC_CODE == 11'h400 || DAC_CODE == 11'h100);
  endproperty
  property p_start;
    $rose(CONV_ACTIVE) |-> $past(AVM_WRITE) || $past(AVM_WRITE, 2) || $past(AVM_WRITE, 3);
  endproperty
  property p_irq_fall;
    $fell(IRQ) |-> !$past(AVM_WAITREQUEST) || !$past(AVM_WAITREQUEST, 2);
  endproperty
  a_bus: assert property (p_bus) else $error("bus answer wrong");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not 0");
  a_res_hi: assert property (p_res_hi) else $error("result high too wide");
  a_pad_oe: assert property (p_pad_oe) else $error("pad drive leak");
  a_rdata: assert property (p_rdata) else $error("port read leak");
  a_ibe: assert property (p_ibe) else $error("gated pin active");
  a_dis: assert property (p_dis) else $error("active while disabled");
  a_len: assert property (p_len) else $error("conversion too short");
  a_msb: assert property (p_msb) else $error("first trial code wrong");
  a_start: assert property (p_start) else $error("start without write");
  a_irq_fall: assert property (p_irq_fall) else $error("irq dropped alone");
endmodule

bind adcg_top adcg_chk u_chk (.CORE_CLK(CORE_CLK), .RST_B(RST_B),
  .AVM_ADDRESS(AVM_ADDRESS), .AVM_READ(AVM_READ), .AVM_WRITE(AVM_WRITE),
  .AVM_READDATA(AVM_READDATA), .AVM_WAITREQUEST(AVM_WAITREQUEST),
  .DAC_CODE(DAC_CODE), .CH_SEL(CH_SEL), .CONV_ACTIVE(CONV_ACTIVE),
  .PORT_OE(PORT_OE), .PIN_IN(PIN_IN), .PAD_OE(PAD_OE), .PAD_PULL(PAD_PULL),
  .PAD_IBE(PAD_IBE), .PORT_RDATA(PORT_RDATA), .IRQ(IRQ));
`default_nettype wire

// ==== dv/tb_top.sv ====
// self-checking bench for adcg_top with an ideal comparator model
// assumes the checker file compiled alongside
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  // ****
  // bench
  // ****
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] adr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic wait_r;
  logic comp;
  logic [10:0] dac;
  logic [4:0] ch;
  logic act;
  logic [15:0] p_oe = 16'h0;
  logic [15:0] p_pu = 16'h0;
  logic [15:0] p_in = 16'h0;
  logic [15:0] pad_oe;
  logic [15:0] pad_pu;
  logic [15:0] pad_ibe;
  logic [15:0] port_rd;
  logic irq;
  logic [10:0] vin = 11'h0;
  logic [15:0] lfsr_q = 16'h1;
  logic [31:0] r;
  int fails = 0;
  int cmp_count = 0;
  int cyc = 0;

  adcg_top DUT (.CORE_CLK(clk), .RST_B(rst_b), .AVM_ADDRESS(adr), .AVM_READ(rd),
    .AVM_WRITE(wr), .AVM_WRITEDATA(wdat), .AVM_READDATA(rdat),
    .AVM_WAITREQUEST(wait_r), .COMP_IN(comp), .DAC_CODE(dac), .CH_SEL(ch),
    .CONV_ACTIVE(act), .PORT_OE(p_oe), .PORT_PULL(p_pu), .PIN_IN(p_in),
    .PAD_OE(pad_oe), .PAD_PULL(pad_pu), .PAD_IBE(pad_ibe), .PORT_RDATA(port_rd),
    .IRQ(irq));

  always #25 clk = ~clk;
  // ideal comparator, follows the trial code within the cycle
  assign comp = (vin >= dac);

  function automatic logic [15:0] rnd();
    lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    return lfsr_q;
  endfunction

  // rounding of the raw approximation, saturating at full scale
  function automatic int exp_res(input int raw, input bit ten);
    int h;
    h = ten ? raw >> 1 : (raw >> 1) & 255;
    if (ten ? h == 1023 : h == 255)
      return h;
    return h + (raw & 1);
  endfunction

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    adr <= a;
    wr <= w;
    rd <= !w;
    wdat <= d;
    do @(posedge clk); while (wait_r !== 1'b0);
    r = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  task automatic conv_wait();
    repeat (3) @(posedge clk);
    do bus(1'b0, 4'ha, 32'h0); while (r[0] !== 1'b0);
  endtask

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fails++;
      report_and_stop();
    end
  end

  initial
  begin
    logic [15:0] g;
    logic [10:0] v;
    logic ten;
    logic completion_irq_enable;
    int e;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    bus(1'b0, 4'h6, 32'h0);
    check(r, 32'h0);
    bus(1'b0, 4'h7, 32'h0);
    check(r, 32'h0);
    check({27'h0, ch}, 32'h1f);
    bus(1'b0, 4'ha, 32'h0);
    check({31'h0, r[3]}, 32'h1);
    bus(1'b0, 4'hc, 32'h0);
    check(r, 32'h0);
    $display("test reset done");
    g = rnd();
    bus(1'b1, 4'h6, {24'h0, g[7:0]});
    bus(1'b1, 4'h7, {24'h0, g[15:8]});
    bus(1'b0, 4'h6, 32'h0);
    check(r, {24'h0, g[7:0]});
    bus(1'b0, 4'h7, 32'h0);
    check(r, {24'h0, g[15:8]});
    p_oe <= rnd();
    p_pu <= rnd();
    p_in <= rnd();
    repeat (3) @(posedge clk);
    check({16'h0, pad_oe}, {16'h0, p_oe & ~g});
    check({16'h0, pad_pu}, {16'h0, p_pu & ~g});
    check({16'h0, pad_ibe}, {16'h0, ~g});
    check({16'h0, port_rd}, {16'h0, p_in & ~g});
    $display("test gating done");
    bus(1'b1, 4'h9, 32'h3);
    for (int i = 0; i < 8; i++)
    begin
      ten = i < 4;
      completion_irq_enable = i % 4 != 2;
      v = (i % 4 == 0) ? 11'h7ff : (i % 4 == 1) ? 11'h0 : 11'(rnd());
      vin <= ten ? v : v & 11'h1ff;
      bus(1'b1, 4'h1, ten ? 32'h8 : 32'h0);
      bus(1'b1, 4'h0, {25'h0, completion_irq_enable, 6'h03});
      conv_wait();
      check({30'h0, r[2:1]}, 32'h3);
      check({31'h0, irq}, {31'h0, completion_irq_enable});
      bus(1'b0, 4'h8, 32'h0);
      check({31'h0, r[0]}, {31'h0, completion_irq_enable});
      e = exp_res(vin, ten);
      bus(1'b0, 4'h4, 32'h0);
      check(r, e >> 8);
      bus(1'b0, 4'h5, 32'h0);
      check(r, e & 255);
    end
    $display("test conversion done");
    bus(1'b1, 4'h2, 32'h3);
    bus(1'b1, 4'h3, 32'h3ff);
    vin <= 11'h0;
    bus(1'b1, 4'h0, 32'h43);
    conv_wait();
    check({31'h0, r[1]}, 32'h0);
    bus(1'b0, 4'h8, 32'h0);
    check({30'h0, r[1:0]}, 32'h2);
    bus(1'b1, 4'h3, 32'h0);
    bus(1'b1, 4'h0, 32'h43);
    conv_wait();
    check({31'h0, r[1]}, 32'h1);
    bus(1'b1, 4'h2, 32'h1);
    bus(1'b1, 4'h0, 32'h43);
    conv_wait();
    check({31'h0, r[1]}, 32'h0);
    bus(1'b0, 4'h8, 32'h0);
    check({30'h0, r[1:0]}, 32'h3);
    bus(1'b1, 4'h0, 32'h63);
    repeat (40) @(posedge clk);
    check({31'h0, act}, 32'h1);
    bus(1'b1, 4'h0, 32'h1f);
    repeat (3) @(posedge clk);
    check({31'h0, act}, 32'h0);
    $display("test compare done");
    report_and_stop();
  end
endmodule
`default_nettype wire

// ==== logic/adcg_params.svh ====
// constants for the converter control block: offsets, fields, resets
// assumes a word-addressed Avalon-MM slave port and a synchronous comparator
//
// Notes on behaviour
// - pin gate register for channels 15..8, bit 7 is channel 15
// - pin gate register for channels 23..16, bit 7 is channel 23
// - gate bit 0 keeps digital pin control, 1 turns it off
// - a gate register is absent when its channels have no external inputs
// - converter disabled during reset and while channel select is all ones
// - after a completed conversion with none pending, converter goes idle
// - approximation yields 11 bits in 10-bit mode, 9 bits in 8-bit mode
// - 10-bit mode rounds to 10 bits into result high and low
// - 8-bit mode rounds to 8 bits into result low only
// - stored result sets complete flag; interrupt if completion enable and interrupt mask bit 0 set
// - compare enable turns on automatic compare in every mode
// - gated pin: output high impedance, input and pullup off, reads zero
`ifndef ADCG_PARAMS_SVH
`define ADCG_PARAMS_SVH

// ****************************************
// register word indices
// ****************************************
`define ADCG_IDX_CTRL 4'h0
`define ADCG_IDX_CFG 4'h1
`define ADCG_IDX_CMPCTL 4'h2
`define ADCG_IDX_CMPVAL 4'h3
`define ADCG_IDX_RES_HI 4'h4
`define ADCG_IDX_RES_LO 4'h5
`define ADCG_IDX_GATE2 4'h6
`define ADCG_IDX_GATE3 4'h7
`define ADCG_IDX_IRQ_ST 4'h8
`define ADCG_IDX_IRQ_MSK 4'h9
`define ADCG_IDX_STATUS 4'ha

// ****************************************
// fields and reset values
// ****************************************
`define ADCG_CH_ALL_ONES 5'h1f
`define ADCG_CTRL_CONT 5
`define ADCG_CTRL_COMPLETION_IRQ_ENABLE 6
`define ADCG_MODE_LSB 2
`define ADCG_MODE_8 2'h0
`define ADCG_MODE_10 2'h2
`define ADCG_CMP_ENA 0
`define ADCG_CMP_GT 1
`define ADCG_IRQ_DONE 0
`define ADCG_IRQ_MISS 1
`define ADCG_ST_BUSY 0
`define ADCG_ST_CONVERSION_COMPLETE_FLAG 1
`define ADCG_ST_IDLE 2
`define ADCG_ST_DIS 3
`define ADCG_SAR_TOP10 11'h400
`define ADCG_SAR_TOP8 11'h100
`define ADCG_GATE_RST 8'h00

`endif

// ==== logic/adcg_pkg.sv ====
// types and shared arithmetic for the converter control block
// assumes adcg_params.svh on the include path
`include "adcg_params.svh"

package adcg_pkg;

  typedef enum logic [1:0] {ST_DISABLED, ST_IDLE, ST_CONVERT, ST_STORE} adcg_state_e;
  typedef logic [10:0] adcg_raw_t;

  // round raw approximation to 10 or 8 bits, saturating at full scale
  function automatic logic [9:0] adcg_round(input adcg_raw_t raw, input logic ten);
    logic [9:0] res;
    res = 10'h000;
    if (ten)
    begin
      res = (&raw[10:1]) ? raw[10:1] : raw[10:1] + {9'h000, raw[0]};
    end
    else
    begin
      res = (&raw[8:1]) ? {2'h0, raw[8:1]} : {2'h0, raw[8:1] + {7'h00, raw[0]}};
    end
    return res;
  endfunction

endpackage

// ==== logic/adcg_sar.sv ====
// successive-approximation sequencer, one bit per clock
// assumes comparator input valid in the same clock cycle as the trial code it answers
`timescale 1ns/100ps
`default_nettype none
`include "adcg_params.svh"

module adcg_sar
  import adcg_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic start,
  input wire logic abort,
  input wire logic ten_bit,
  input wire logic comp_in,
  output logic busy,
  output logic done,
  output adcg_raw_t result,
  output adcg_raw_t dac_code
);

  logic busy_q, busy_d;
  logic done_q, done_d;
  adcg_raw_t acc_q, acc_d;
  adcg_raw_t bit_q, bit_d;
  adcg_raw_t dac_q, dac_d;
  adcg_raw_t res_q, res_d;
  adcg_raw_t kept;

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    busy_d = busy_q;
    done_d = 1'b0;
    acc_d = acc_q;
    bit_d = bit_q;
    dac_d = dac_q;
    res_d = res_q;
    kept = comp_in ? dac_q : acc_q;
    if (start)
    begin
      // 11 trials in 10-bit mode, 9 in 8-bit mode
      busy_d = 1'b1;
      acc_d = '0;
      bit_d = ten_bit ? `ADCG_SAR_TOP10 : `ADCG_SAR_TOP8;
      dac_d = ten_bit ? `ADCG_SAR_TOP10 : `ADCG_SAR_TOP8;
    end
    else if (abort)
    begin
      busy_d = 1'b0;
    end
    else if (busy_q)
    begin
      acc_d = kept;
      bit_d = bit_q >> 1;
      if (bit_q[0])
      begin
        busy_d = 1'b0;
        done_d = 1'b1;
        res_d = kept;
      end
      else
      begin
        dac_d = kept | (bit_q >> 1);
      end
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      acc_q <= '0;
      bit_q <= '0;
      dac_q <= '0;
      res_q <= '0;
    end
    else
    begin
      busy_q <= busy_d;
      done_q <= done_d;
      acc_q <= acc_d;
      bit_q <= bit_d;
      dac_q <= dac_d;
      res_q <= res_d;
    end
  end

  assign busy = busy_q;
  assign done = done_q;
  assign result = res_q;
  assign dac_code = dac_q;

endmodule
`default_nettype wire

// ==== logic/adcg_top.sv ====
// converter control: registers, pin gating, conversion sequencing, interrupt
// assumes Avalon-MM word addressing and pad/port signals synchronous to CORE_CLK
`timescale 1ns/100ps
`default_nettype none
`include "adcg_params.svh"

module adcg_top
  import adcg_pkg::*;
#(
  parameter bit HAS_CH8_15 = 1'b1,
  parameter bit HAS_CH16_23 = 1'b1
)
(
  input wire logic CORE_CLK,
  input wire logic RST_B,
  input wire logic [3:0] AVM_ADDRESS,
  input wire logic AVM_READ,
  input wire logic AVM_WRITE,
  input wire logic [31:0] AVM_WRITEDATA,
  output logic [31:0] AVM_READDATA,
  output logic AVM_WAITREQUEST,
  input wire logic COMP_IN,
  output logic [10:0] DAC_CODE,
  output logic [4:0] CH_SEL,
  output logic CONV_ACTIVE,
  input wire logic [15:0] PORT_OE,
  input wire logic [15:0] PORT_PULL,
  input wire logic [15:0] PIN_IN,
  output logic [15:0] PAD_OE,
  output logic [15:0] PAD_PULL,
  output logic [15:0] PAD_IBE,
  output logic [15:0] PORT_RDATA,
  output logic IRQ
);

  // ****************************************
  // declarations
  // ****************************************
  logic wait_q, wait_d;
  logic [31:0] rdata_q, rdata_d;
  logic wr_go, rd_go;
  logic [4:0] ch_q, ch_d;
  logic cont_q, cont_d;
  logic completion_irq_enable_q, completion_irq_enable_d;
  logic [1:0] mode_q, mode_d;
  logic compare_function_enable_q, compare_function_enable_d;
  logic acgt_q, acgt_d;
  logic [9:0] cval_q, cval_d;
  logic [9:0] res_q, res_d;
  logic [7:0] gate2_q, gate2_d;
  logic [7:0] gate3_q, gate3_d;
  logic conversion_complete_flag_q, conversion_complete_flag_d;
  logic [1:0] ist_q, ist_d;
  logic [1:0] imsk_q, imsk_d;
  logic irq_q, irq_d;
  adcg_state_e state_q, state_d;
  logic act_q, act_d;
  logic [15:0] oe_q, oe_d;
  logic [15:0] pull_q, pull_d;
  logic [15:0] ibe_q, ibe_d;
  logic [15:0] prd_q, prd_d;
  logic [15:0] gate_all;
  logic ten_bit;
  logic ctrl_wr, cfg_wr, start_req, sar_start, sar_abort;
  logic sar_done;
  logic store, miss;
  adcg_raw_t sar_res;
  logic [9:0] rounded;
  logic cmp_pass;

  assign wr_go = AVM_WRITE && !wait_q;
  assign rd_go = AVM_READ && !wait_q;
  assign ten_bit = (mode_q == `ADCG_MODE_10);
  assign gate_all = {gate3_q, gate2_q};
  assign ctrl_wr = wr_go && (AVM_ADDRESS == `ADCG_IDX_CTRL);
  assign cfg_wr = wr_go && ((AVM_ADDRESS == `ADCG_IDX_CFG) ||
                            (AVM_ADDRESS == `ADCG_IDX_CMPCTL) ||
                            (AVM_ADDRESS == `ADCG_IDX_CMPVAL));
  assign start_req = ctrl_wr && (AVM_WRITEDATA[4:0] != `ADCG_CH_ALL_ONES);
  assign rounded = adcg_round(sar_res, ten_bit);

  // compare in the width of the active mode
  always_comb
  begin
    cmp_pass = 1'b1;
    if (compare_function_enable_q)
    begin
      if (ten_bit)
      begin
        cmp_pass = acgt_q ? (rounded >= cval_q) : (rounded < cval_q);
      end
      else
      begin
        cmp_pass = acgt_q ? (rounded[7:0] >= cval_q[7:0]) : (rounded[7:0] < cval_q[7:0]);
      end
    end
  end

  // ****************************************
  // read data mux
  // ****************************************
  function automatic logic [31:0] read_word(input logic [3:0] idx);
    logic [31:0] w;
    w = 32'h0000_0000;
    unique case (idx)
      `ADCG_IDX_CTRL: w = {25'h0, completion_irq_enable_q, cont_q, ch_q};
      `ADCG_IDX_CFG: w = {28'h0, mode_q, 2'h0};
      `ADCG_IDX_CMPCTL: w = {30'h0, acgt_q, compare_function_enable_q};
      `ADCG_IDX_CMPVAL: w = {22'h0, cval_q};
      `ADCG_IDX_RES_HI: w = {30'h0, res_q[9:8]};
      `ADCG_IDX_RES_LO: w = {24'h0, res_q[7:0]};
      `ADCG_IDX_GATE2: w = {24'h0, gate2_q};
      `ADCG_IDX_GATE3: w = {24'h0, gate3_q};
      `ADCG_IDX_IRQ_ST: w = {30'h0, ist_q};
      `ADCG_IDX_IRQ_MSK: w = {30'h0, imsk_q};
      `ADCG_IDX_STATUS: w = {28'h0, state_q == ST_DISABLED, state_q == ST_IDLE,
                             conversion_complete_flag_q, act_q};
      default: w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  // ****************************************
  // bus slave: one wait cycle per access
  // ****************************************
  always_comb
  begin
    wait_d = 1'b1;
    rdata_d = rdata_q;
    if ((AVM_READ || AVM_WRITE) && wait_q)
    begin
      wait_d = 1'b0;
      rdata_d = AVM_READ ? read_word(AVM_ADDRESS) : 32'h0000_0000;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      wait_q <= wait_d;
      rdata_q <= rdata_d;
    end
  end

  // ****************************************
  // conversion sequencer
  // ****************************************
  always_comb
  begin
    state_d = state_q;
    sar_start = 1'b0;
    sar_abort = 1'b0;
    store = 1'b0;
    miss = 1'b0;
    unique case (state_q)
      ST_DISABLED, ST_IDLE:
      begin
        if (start_req)
        begin
          sar_start = 1'b1;
          state_d = ST_CONVERT;
        end
        else
        begin
          state_d = (ch_q == `ADCG_CH_ALL_ONES) ? ST_DISABLED : ST_IDLE;
        end
      end
      ST_CONVERT:
      begin
        if (ctrl_wr)
        begin
          sar_start = start_req;
          sar_abort = !start_req;
          state_d = start_req ? ST_CONVERT : ST_DISABLED;
        end
        else if (cfg_wr)
        begin
          sar_abort = 1'b1;
          state_d = ST_IDLE;
        end
        else if (sar_done)
        begin
          state_d = ST_STORE;
        end
      end
      ST_STORE:
      begin
        store = cmp_pass;
        miss = !cmp_pass;
        if (ctrl_wr && !start_req)
        begin
          state_d = ST_DISABLED;
        end
        else if (cont_q || start_req)
        begin
          sar_start = 1'b1;
          state_d = ST_CONVERT;
        end
        else
        begin
          state_d = ST_IDLE;
        end
      end
    endcase
    act_d = (state_d == ST_CONVERT) || (state_d == ST_STORE);
  end

  always_ff @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      state_q <= ST_DISABLED;
      act_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      act_q <= act_d;
    end
  end

  adcg_sar u_sar (
    .clk(CORE_CLK),
    .rst_b(RST_B),
    .start(sar_start),
    .abort(sar_abort),
    .ten_bit(ten_bit),
    .comp_in(COMP_IN),
    .busy(),
    .done(sar_done),
    .result(sar_res),
    .dac_code(DAC_CODE)
  );

  // ****************************************
  // software registers and flags
  // ****************************************
  always_comb
  begin
    ch_d = ch_q;
    cont_d = cont_q;
    completion_irq_enable_d = completion_irq_enable_q;
    mode_d = mode_q;
    compare_function_enable_d = compare_function_enable_q;
    acgt_d = acgt_q;
    cval_d = cval_q;
    res_d = res_q;
    gate2_d = gate2_q;
    gate3_d = gate3_q;
    imsk_d = imsk_q;
    conversion_complete_flag_d = conversion_complete_flag_q;
    ist_d = ist_q;
    if (wr_go)
    begin
      unique case (AVM_ADDRESS)
        `ADCG_IDX_CTRL:
        begin
          ch_d = AVM_WRITEDATA[4:0];
          cont_d = AVM_WRITEDATA[`ADCG_CTRL_CONT];
          completion_irq_enable_d = AVM_WRITEDATA[`ADCG_CTRL_COMPLETION_IRQ_ENABLE];
        end
        `ADCG_IDX_CFG: mode_d = AVM_WRITEDATA[`ADCG_MODE_LSB +: 2];
        `ADCG_IDX_CMPCTL:
        begin
          compare_function_enable_d = AVM_WRITEDATA[`ADCG_CMP_ENA];
          acgt_d = AVM_WRITEDATA[`ADCG_CMP_GT];
        end
        `ADCG_IDX_CMPVAL: cval_d = AVM_WRITEDATA[9:0];
        `ADCG_IDX_GATE2: gate2_d = HAS_CH8_15 ? AVM_WRITEDATA[7:0] : `ADCG_GATE_RST;
        `ADCG_IDX_GATE3: gate3_d = HAS_CH16_23 ? AVM_WRITEDATA[7:0] : `ADCG_GATE_RST;
        `ADCG_IDX_IRQ_MSK: imsk_d = AVM_WRITEDATA[1:0];
        default: ;
      endcase
    end
    // status read clears only the bits it returned; result low clears at capture
    if (rd_go && (AVM_ADDRESS == `ADCG_IDX_IRQ_ST))
    begin
      ist_d = ist_q & ~rdata_q[1:0];
    end
    if (ctrl_wr || (AVM_READ && wait_q && (AVM_ADDRESS == `ADCG_IDX_RES_LO)))
    begin
      conversion_complete_flag_d = 1'b0;
    end
    // hardware set wins over the clears above
    if (store)
    begin
      res_d = rounded;
      conversion_complete_flag_d = 1'b1;
      ist_d[`ADCG_IRQ_DONE] = ist_q[`ADCG_IRQ_DONE] | completion_irq_enable_q;
    end
    if (miss)
    begin
      ist_d[`ADCG_IRQ_MISS] = 1'b1;
    end
    irq_d = |(ist_d & imsk_d);
  end

  always_ff @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      ch_q <= `ADCG_CH_ALL_ONES;
      cont_q <= 1'b0;
      completion_irq_enable_q <= 1'b0;
      mode_q <= `ADCG_MODE_8;
      compare_function_enable_q <= 1'b0;
      acgt_q <= 1'b0;
      cval_q <= 10'h000;
      res_q <= 10'h000;
      gate2_q <= `ADCG_GATE_RST;
      gate3_q <= `ADCG_GATE_RST;
      imsk_q <= 2'h0;
      conversion_complete_flag_q <= 1'b0;
      ist_q <= 2'h0;
      irq_q <= 1'b0;
    end
    else
    begin
      ch_q <= ch_d;
      cont_q <= cont_d;
      completion_irq_enable_q <= completion_irq_enable_d;
      mode_q <= mode_d;
      compare_function_enable_q <= compare_function_enable_d;
      acgt_q <= acgt_d;
      cval_q <= cval_d;
      res_q <= res_d;
      gate2_q <= gate2_d;
      gate3_q <= gate3_d;
      imsk_q <= imsk_d;
      conversion_complete_flag_q <= conversion_complete_flag_d;
      ist_q <= ist_d;
      irq_q <= irq_d;
    end
  end

  // ****************************************
  // pad gating, bit i is channel 8+i
  // ****************************************
  always_comb
  begin
    oe_d = PORT_OE & ~gate_all;
    pull_d = PORT_PULL & ~gate_all;
    ibe_d = ~gate_all;
    prd_d = PIN_IN & ~gate_all;
  end

  always_ff @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      oe_q <= 16'h0000;
      pull_q <= 16'h0000;
      ibe_q <= 16'hffff;
      prd_q <= 16'h0000;
    end
    else
    begin
      oe_q <= oe_d;
      pull_q <= pull_d;
      ibe_q <= ibe_d;
      prd_q <= prd_d;
    end
  end

  assign AVM_READDATA = rdata_q;
  assign AVM_WAITREQUEST = wait_q;
  assign CH_SEL = ch_q;
  assign CONV_ACTIVE = act_q;
  assign PAD_OE = oe_q;
  assign PAD_PULL = pull_q;
  assign PAD_IBE = ibe_q;
  assign PORT_RDATA = prd_q;
  assign IRQ = irq_q;

endmodule
`default_nettype wire
